// ===== verilog/motor_pkg.sv
package motor_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int PWM_HZ = 19_200;
   localparam int PWM_PERIOD = CLK_HZ / PWM_HZ;
   localparam int HALF_DUTY = PWM_PERIOD / 2;
   localparam int DEAD_NS = 1000;
   localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
   localparam int CAP_PRESCALE = 128;
   localparam logic [15:0] CAP_WRAP = 16'hFFFF;
   localparam int POLE_PAIRS = 2;
   localparam int RPM_NUM = (CLK_HZ / CAP_PRESCALE) * 60 / POLE_PAIRS;
   localparam logic [15:0] MIN_PI_RPM = 16'd499;
   localparam logic [15:0] MIN_RPM = 16'd500;
   localparam logic [15:0] MAX_RPM = 16'd4000;
   localparam logic [15:0] RAMP_STEP = 16'd20;
   localparam int PRECHARGE_TICKS = 2;
   localparam int SPI_HALF = 50;
   localparam logic [15:0] KP_RST = 16'h0100;
   localparam logic [15:0] KI_RST = 16'h0010;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SPEED_REQ = 8'h04;
   localparam logic [7:0] REG_GAINS = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_SPEED_MEAS = 8'h10;
   localparam logic [7:0] REG_DUTY = 8'h14;
   localparam logic [7:0] REG_SPI = 8'h18;
   localparam int CTRL_DIR = 0;
   localparam int CTRL_COMPL = 1;
   localparam int CTRL_BIPOLAR = 2;
   localparam int CTRL_RESTART = 3;
   localparam int SPI_BUSY = 16;

   typedef enum logic [1:0] {ST_IDLE, ST_PRECHARGE, ST_RUN, ST_FAULT} state_e;

   // Returns {high phases, low phases}, bits A,B,C from 2 down to 0.
   function automatic logic [5:0] commDecode(input logic [2:0] hall, input logic ccw);
      logic [5:0] p;
      case (hall)
         3'b011: p = {3'b010, 3'b100};
         3'b010: p = {3'b010, 3'b001};
         3'b110: p = {3'b100, 3'b001};
         3'b100: p = {3'b100, 3'b010};
         3'b101: p = {3'b001, 3'b010};
         3'b001: p = {3'b001, 3'b100};
         default: p = 6'h00;
      endcase
      return ccw ? {p[2:0], p[5:3]} : p;
   endfunction
endpackage

// ===== verilog/hall_six_step_motor_drive.sv
`timescale 1ns/10ps
// Operation
// - Complementary mode turns on the opposite switch while freewheeling.
// - Independent mode turns the whole leg off while freewheeling.
// - Bipolar mode swaps top and bottom PWM on the low leg.
// - One microsecond dead time between a gate and its partner.
// - Paired PWM at 19.2 kHz from the core clock.
// - Clockwise Hall table selects high, low and floating phases.
// - Six valid Hall states, one commutation per state change.
// - Every Hall edge updates the pattern without the speed loop.
// - Commutation swaps and masks channels independently of loop timing.
// - Nonzero request enables Hall response and forces first commutation.
// - Start from any rotor position using the present Hall state.
// - Precharge bootstrap capacitors before every start.
// - Both directions, sequence chosen by requested direction.
// - Speed is set only through the PWM duty.
// - Speed error is required minus measured speed.
// - Output is proportional plus integral term.
// - Integral adds gain times error each step, backward Euler.
// - Ramp, PI loop and precharge timing run from a 10 ms tick.
// - Measured speed comes from the period of Hall A.
// - Capture timer prescaled by 128, wraps at 0xFFFF.
// - Speed command range is 500 to 4000 RPM.
// - Watch overcurrent input and drive a first-level flag output.
// - Emergency stop input stops driving the motor.
// - Predriver is configured and queried over SPI.
// - Integral frozen while measured speed is below 499 RPM.
// - Duty is half scale plus the PI output.
// - Timer overflow without capture means stopped and resets the ramp.
// - Six gate outputs, upper and lower per phase.
module hall_six_step_motor_drive
   import motor_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Sensors and protection.
   input wire logic hallA,
   input wire logic hallB,
   input wire logic hallC,
   input wire logic emergencyStop,
   input wire logic overcurrentSense,
   output logic overcurrentLevel1Flag,
   // Gate drive, bit 2 is phase A.
   output logic [2:0] gateHigh,
   output logic [2:0] gateLow,
   // Predriver SPI.
   output logic spiSclk,
   output logic spiMosi,
   output logic spiCsN,
   input wire logic spiMiso
);
   ////////////////////////////////////////////////////////////////////
   logic [4:0] sync1, sync2;
   logic [2:0] hallS;
   logic estopS, ocS, misoS, sync1Miso, faultNow;
   always_ff @(posedge clk) begin
      sync1 <= {hallA, hallB, hallC, emergencyStop, overcurrentSense};
      sync2 <= sync1;
   end
   assign hallS = sync2[4:2];
   assign estopS = sync2[1];
   assign ocS = sync2[0];
   assign faultNow = estopS | ocS;

   ////////////////////////////////////////////////////////////////////
   logic [31:0] wbMerged;
   logic wbWr, restart, spiStart;
   logic [3:0] ctrl;
   logic [15:0] speedReq, kp, ki, spiRx, measSpeed;
   logic [3:0] next_ctrl;
   logic [15:0] next_speedReq, next_kp, next_ki;
   logic [31:0] next_rd;
   logic next_ack;
   state_e state;
   logic stopped, spiBusy;
   logic [12:0] duty;
   always_comb begin
      case (wb_adr_i)
         REG_CTRL: next_rd = {28'h000_0000, ctrl};
         REG_SPEED_REQ: next_rd = {16'h0000, speedReq};
         REG_GAINS: next_rd = {ki, kp};
         REG_STATUS: next_rd = {24'h00_0000, state, stopped,
            overcurrentLevel1Flag, estopS, hallS};
         REG_SPEED_MEAS: next_rd = {16'h0000, measSpeed};
         REG_DUTY: next_rd = {19'h0_0000, duty};
         REG_SPI: next_rd = {15'h0000, spiBusy, spiRx};
         default: next_rd = 32'h0000_0000;
      endcase
      // Unselected bytes keep the register's present contents.
      for (int b = 0; b < 4; b++) begin
         wbMerged[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : next_rd[8*b +: 8];
      end
      wbWr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
      restart = wbWr && wb_adr_i == REG_CTRL && wbMerged[CTRL_RESTART];
      spiStart = wbWr && wb_adr_i == REG_SPI && !spiBusy;
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_ctrl = ctrl;
      next_speedReq = speedReq;
      next_kp = kp;
      next_ki = ki;
      if (wbWr && wb_adr_i == REG_CTRL) begin
         next_ctrl = {1'b0, wbMerged[2:0]};
      end
      if (wbWr && wb_adr_i == REG_SPEED_REQ) begin
         next_speedReq = wbMerged[15:0];
      end
      if (wbWr && wb_adr_i == REG_GAINS) begin
         next_kp = wbMerged[15:0];
         next_ki = wbMerged[31:16];
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl <= 4'h0;
         speedReq <= 16'h0000;
         kp <= KP_RST;
         ki <= KI_RST;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_rd;
         ctrl <= next_ctrl;
         speedReq <= next_speedReq;
         kp <= next_kp;
         ki <= next_ki;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [6:0] preCnt, next_preCnt;
   logic [15:0] capTimer, lastCap, period, ramp, target;
   logic [15:0] next_capTimer, next_lastCap, next_period, next_ramp, next_measSpeed;
   logic [19:0] tickCnt, next_tickCnt;
   logic [1:0] preTicks, next_preTicks;
   logic [2:0] pattHall, next_pattHall;
   logic [33:0] integ, next_integ, prop, sum, dutyS;
   logic [16:0] err;
   logic [12:0] next_duty;
   state_e next_state;
   logic sawCap, hadCap, next_sawCap, next_hadCap, next_stopped, next_ocFlag;
   logic tick, ovf, capEdge, divGo, hallPrevA, divDone;
   logic [15:0] divQ;
   always_comb begin
      next_preCnt = preCnt + 7'd1;
      next_capTimer = capTimer;
      ovf = 1'b0;
      if (preCnt == 7'(CAP_PRESCALE - 1)) begin
         next_capTimer = capTimer + 16'h0001;
         ovf = capTimer == CAP_WRAP;
      end
      tick = tickCnt == 20'(TICK_CYCLES - 1);
      next_tickCnt = tick ? 20'h0_0000 : tickCnt + 20'h0_0001;
      capEdge = hallS[2] & ~hallPrevA;
      next_lastCap = lastCap;
      next_period = period;
      next_sawCap = sawCap;
      next_hadCap = hadCap;
      next_stopped = stopped;
      next_measSpeed = divDone ? divQ : measSpeed;
      next_ramp = ramp;
      divGo = 1'b0;
      if (capEdge) begin
         next_period = capTimer - lastCap;
         next_lastCap = capTimer;
         next_sawCap = 1'b1;
         next_hadCap = 1'b1;
         divGo = hadCap;
         next_stopped = 1'b0;
      end else if (ovf) begin
         next_sawCap = 1'b0;
         if (!sawCap) begin
            next_stopped = 1'b1;
            next_hadCap = 1'b0;
            next_measSpeed = 16'h0000;
            next_ramp = 16'h0000;
         end
      end
      // Command clamped to the drive's speed range.
      target = speedReq > MAX_RPM ? MAX_RPM : (speedReq < MIN_RPM ? MIN_RPM : speedReq);
      err = {1'b0, ramp} - {1'b0, measSpeed};
      prop = 34'(($signed({1'b0, kp}) * $signed(err)) >>> 8);
      next_integ = integ;
      sum = 34'h0_0000_0000;
      dutyS = 34'h0_0000_0000;
      next_duty = duty;
      next_state = state;
      next_preTicks = preTicks;
      next_pattHall = state == ST_RUN ? hallS : pattHall;
      next_ocFlag = ocS | (overcurrentLevel1Flag & ~restart);
      case (state)
         ST_IDLE: begin
            next_integ = 34'h0_0000_0000;
            next_duty = 13'(HALF_DUTY);
            if (speedReq != 16'h0000) begin
               next_state = ST_PRECHARGE;
               next_preTicks = 2'd0;
            end
         end
         ST_PRECHARGE: begin
            if (tick) begin
               next_preTicks = preTicks + 2'd1;
               if (preTicks == 2'(PRECHARGE_TICKS - 1)) begin
                  next_state = ST_RUN;
                  next_pattHall = hallS;
               end
            end
         end
         ST_RUN: begin
            if (speedReq == 16'h0000) begin
               next_state = ST_IDLE;
            end else if (tick) begin
               if (ramp < target) begin
                  next_ramp = target - ramp > RAMP_STEP ? ramp + RAMP_STEP : target;
               end else begin
                  next_ramp = ramp - target > RAMP_STEP ? ramp - RAMP_STEP : target;
               end
               if (measSpeed >= MIN_PI_RPM) begin
                  next_integ = integ + 34'(($signed({1'b0, ki}) * $signed(err)) >>> 8);
                  if ($signed(next_integ) > HALF_DUTY) next_integ = 34'(HALF_DUTY);
                  if ($signed(next_integ) < -HALF_DUTY) next_integ = 34'(-HALF_DUTY);
               end
               sum = prop + next_integ;
               dutyS = 34'(HALF_DUTY) + sum;
               if ($signed(dutyS) < 0) next_duty = 13'h0000;
               else if ($signed(dutyS) > PWM_PERIOD) next_duty = 13'(PWM_PERIOD);
               else next_duty = dutyS[12:0];
            end
         end
         ST_FAULT: begin
            if (!faultNow && restart) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // A stop seen in a tick cycle must still clear the ramp.
      if (!capEdge && ovf && !sawCap) next_ramp = 16'h0000;
      if (faultNow) next_state = ST_FAULT;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         preCnt <= 7'h00;
         capTimer <= 16'h0000;
         lastCap <= 16'h0000;
         period <= 16'h0000;
         tickCnt <= 20'h0_0000;
         sawCap <= 1'b0;
         hadCap <= 1'b0;
         stopped <= 1'b1;
         measSpeed <= 16'h0000;
         ramp <= 16'h0000;
         integ <= 34'h0_0000_0000;
         duty <= 13'(HALF_DUTY);
         state <= ST_IDLE;
         preTicks <= 2'd0;
         pattHall <= 3'b000;
         overcurrentLevel1Flag <= 1'b0;
         hallPrevA <= 1'b0;
      end else begin
         preCnt <= next_preCnt;
         capTimer <= next_capTimer;
         lastCap <= next_lastCap;
         period <= next_period;
         tickCnt <= next_tickCnt;
         sawCap <= next_sawCap;
         hadCap <= next_hadCap;
         stopped <= next_stopped;
         measSpeed <= next_measSpeed;
         ramp <= next_ramp;
         integ <= next_integ;
         duty <= next_duty;
         state <= next_state;
         preTicks <= next_preTicks;
         pattHall <= next_pattHall;
         overcurrentLevel1Flag <= next_ocFlag;
         hallPrevA <= hallS[2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Restoring divider turning the Hall A period into RPM.
   logic [24:0] divNum, next_divNum;
   logic [25:0] divRem, next_divRem, divTry;
   logic [4:0] divCnt, next_divCnt;
   logic divRun, next_divRun;
   always_comb begin
      next_divNum = divNum;
      next_divRem = divRem;
      next_divCnt = divCnt;
      next_divRun = divRun;
      divTry = {divRem[24:0], divNum[24]};
      divDone = 1'b0;
      if (divGo) begin
         next_divNum = 25'(RPM_NUM);
         next_divRem = 26'h000_0000;
         next_divCnt = 5'd0;
         next_divRun = period != 16'h0000;
      end else if (divRun) begin
         next_divNum = {divNum[23:0], divTry >= {10'h000, period}};
         next_divRem = divTry >= {10'h000, period} ? divTry - {10'h000, period} : divTry;
         next_divCnt = divCnt + 5'd1;
         if (divCnt == 5'd24) begin
            next_divRun = 1'b0;
            divDone = 1'b1;
         end
      end
   end
   assign divQ = |next_divNum[24:16] ? 16'hFFFF : next_divNum[15:0];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divNum <= 25'h000_0000;
         divRem <= 26'h000_0000;
         divCnt <= 5'd0;
         divRun <= 1'b0;
      end else begin
         divNum <= next_divNum;
         divRem <= next_divRem;
         divCnt <= next_divCnt;
         divRun <= next_divRun;
      end
   end

   ////////////////////////////////////////////////////////////////////
   logic [12:0] pwmCnt, next_pwmCnt;
   logic [5:0] patt;
   logic pwmOn;
   always_comb begin
      next_pwmCnt = pwmCnt == 13'(PWM_PERIOD - 1) ? 13'h0000 : pwmCnt + 13'h0001;
   end
   assign pwmOn = pwmCnt < duty;
   assign patt = commDecode(pattHall, ctrl[CTRL_DIR]);
   always_ff @(posedge clk) begin
      if (!rst_n) pwmCnt <= 13'h0000;
      else pwmCnt <= next_pwmCnt;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   for (genvar i = 0; i < 3; i++) begin : g_leg
      logic reqTop, reqBot, next_high, next_low;
      logic [7:0] cntTop, cntBot, next_cntTop, next_cntBot;
      always_comb begin
         reqTop = 1'b0;
         reqBot = 1'b0;
         if (faultNow) begin
            reqBot = 1'b0;
         end else if (state == ST_PRECHARGE) begin
            reqBot = 1'b1;
         end else if (state == ST_RUN && patt[3 + i]) begin
            reqTop = pwmOn;
            reqBot = ctrl[CTRL_COMPL] & ~pwmOn;
         end else if (state == ST_RUN && patt[i]) begin
            reqTop = ctrl[CTRL_BIPOLAR] & ctrl[CTRL_COMPL] & ~pwmOn;
            reqBot = ctrl[CTRL_BIPOLAR] ? pwmOn : 1'b1;
         end
         next_cntTop = reqTop && !gateLow[i] && cntTop != 8'(DEAD_CYC) ? cntTop + 8'd1 :
            (reqTop && !gateLow[i] ? cntTop : 8'd0);
         next_cntBot = reqBot && !gateHigh[i] && cntBot != 8'(DEAD_CYC) ? cntBot + 8'd1 :
            (reqBot && !gateHigh[i] ? cntBot : 8'd0);
         next_high = reqTop && !gateLow[i] && cntTop == 8'(DEAD_CYC);
         next_low = reqBot && !gateHigh[i] && cntBot == 8'(DEAD_CYC);
      end
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            cntTop <= 8'd0;
            cntBot <= 8'd0;
            gateHigh[i] <= 1'b0;
            gateLow[i] <= 1'b0;
         end else begin
            cntTop <= next_cntTop;
            cntBot <= next_cntBot;
            gateHigh[i] <= next_high;
            gateLow[i] <= next_low;
         end
      end
      property p_noShoot;
         !(gateHigh[i] && gateLow[i]);
      endproperty
      a_noShoot: assert property (p_noShoot) else $error("Both gates on");
      property p_dead;
         $fell(gateLow[i]) |-> !gateHigh[i] [*8];
      endproperty
      a_dead: assert property (p_dead) else $error("Dead time short");
      property p_float;
         state == ST_RUN && !patt[3 + i] && !patt[i] |=> !gateHigh[i] && !gateLow[i];
      endproperty
      a_float: assert property (p_float) else $error("Float leg driven");
   end

   ////////////////////////////////////////////////////////////////////
   logic [15:0] spiSh, next_spiSh, next_spiRx;
   logic [6:0] spiDiv, next_spiDiv;
   logic [5:0] spiPh, next_spiPh;
   logic next_busy;
   always_comb begin
      next_spiSh = spiSh;
      next_spiRx = spiRx;
      next_spiDiv = spiDiv;
      next_spiPh = spiPh;
      next_busy = spiBusy;
      if (spiStart) begin
         next_spiSh = wbMerged[15:0];
         next_spiDiv = 7'd0;
         next_spiPh = 6'd0;
         next_busy = 1'b1;
      end else if (spiBusy) begin
         next_spiDiv = spiDiv + 7'd1;
         if (spiDiv == 7'(SPI_HALF - 1)) begin
            next_spiDiv = 7'd0;
            next_spiPh = spiPh + 6'd1;
            if (!spiPh[0]) next_spiRx = {spiRx[14:0], misoS}; // Sample on rising SCLK.
            else next_spiSh = {spiSh[14:0], 1'b0};
            if (spiPh == 6'd31) next_busy = 1'b0;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         spiSh <= 16'h0000;
         spiRx <= 16'h0000;
         spiDiv <= 7'd0;
         spiPh <= 6'd0;
         spiBusy <= 1'b0;
         misoS <= 1'b0;
      end else begin
         spiSh <= next_spiSh;
         spiRx <= next_spiRx;
         spiDiv <= next_spiDiv;
         spiPh <= next_spiPh;
         spiBusy <= next_busy;
         misoS <= sync1Miso;
      end
   end
   always_ff @(posedge clk) sync1Miso <= spiMiso;
   assign spiCsN = ~spiBusy;
   assign spiSclk = spiBusy & spiPh[0];
   assign spiMosi = spiSh[15];

   ////////////////////////////////////////////////////////////////////
   sequence s_faultSeen;
      faultNow;
   endsequence
   property p_fault;
      s_faultSeen |=> gateHigh == 3'b000 && gateLow == 3'b000 && state == ST_FAULT;
   endproperty
   a_fault: assert property (p_fault) else $error("Gates on in fault");
   property p_start;
      state == ST_IDLE && speedReq != 16'h0000 && !faultNow |=> state == ST_PRECHARGE;
   endproperty
   a_start: assert property (p_start) else $error("No start");
   property p_precharge;
      state == ST_PRECHARGE && !faultNow |=> gateHigh == 3'b000;
   endproperty
   a_precharge: assert property (p_precharge) else $error("Top on in precharge");
   property p_stop;
      ovf && !capEdge && !sawCap |=> stopped && measSpeed == 16'h0000 && ramp == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("Stop not seen");
   property p_integ;
      tick && state == ST_RUN && measSpeed < MIN_PI_RPM && !faultNow |=> integ == $past(integ);
   endproperty
   a_integ: assert property (p_integ) else $error("Integral moved");
   property p_tick;
      tick |=> !tick [*8];
   endproperty
   a_tick: assert property (p_tick) else $error("Tick too fast");
   property p_duty;
      duty <= 13'(PWM_PERIOD);
   endproperty
   a_duty: assert property (p_duty) else $error("Duty out of range");
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("No bus ack");
endmodule // hall_six_step_motor_drive

// ===== dv/hall_predriver_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module hall_predriver_model (
   // Hall sensor side.
   input wire logic [2:0] hallState,
   output logic hallA,
   output logic hallB,
   output logic hallC,
   // Predriver serial target side.
   input wire logic [15:0] reply,
   input wire logic spiSclk,
   input wire logic spiMosi,
   input wire logic spiCsN,
   output logic spiMiso,
   output logic [15:0] rxWord
);
   logic [15:0] shiftOut;
   assign {hallA, hallB, hallC} = hallState;
   // Mode 0 target: load on select, shift out on falling edge, take on rising.
   always @(negedge spiCsN) begin
      shiftOut = reply;
      spiMiso = reply[15];
   end
   always @(posedge spiSclk) if (!spiCsN) rxWord = {rxWord[14:0], spiMosi};
   always @(negedge spiSclk) if (!spiCsN) begin
      shiftOut = {shiftOut[14:0], 1'b0};
      spiMiso = shiftOut[15];
   end
   // Deselected line shows the inverse of its last value.
   always @(posedge spiCsN) spiMiso = ~spiMiso;
   initial spiMiso = 1'b0;
endmodule // hall_predriver_model

// ===== dv/testbench.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
   import motor_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, wbWe = 0, estop = 0, ocs = 0;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, datO, r;
   logic wbAck, ocFlag, hA, hB, hC, sclk, mosi, csN, miso;
   logic [2:0] hall = 3'b011, gH, gL, hi, lo, f;
   logic [15:0] rx, reply = 16'h3C5A, spd, sw;
   logic [31:0] qE[$], qM[$];
   logic [2:0] hSeq[6] = '{3'b011, 3'b010, 3'b110, 3'b100, 3'b101, 3'b001};
   logic [5:0] pSeq[6] = '{6'b010_100, 6'b010_001, 6'b100_001, 6'b100_010, 6'b001_010,
      6'b001_100};
   logic [3:0] modes[4] = '{4'h0, 4'h1, 4'h2, 4'h6};
   int err_total = 0, n_compared = 0, cycles = 0;
   hall_six_step_motor_drive #(.TICK_CYCLES(200)) u_hall_six_step_motor_drive (.clk(clk),
      .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbWe), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(wbAck), .hallA(hA),
      .hallB(hB), .hallC(hC), .emergencyStop(estop), .overcurrentSense(ocs),
      .overcurrentLevel1Flag(ocFlag), .gateHigh(gH), .gateLow(gL), .spiSclk(sclk),
      .spiMosi(mosi), .spiCsN(csN), .spiMiso(miso));
   hall_predriver_model u_hall_predriver_model (.hallState(hall), .hallA(hA), .hallB(hB),
      .hallC(hC), .reply(reply), .spiSclk(sclk), .spiMosi(mosi), .spiCsN(csN),
      .spiMiso(miso), .rxWord(rx));
   initial forever #5 clk = ~clk;
   task automatic cmp(input string n, input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1;
      stb <= 1;
      wbWe <= we;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (wbAck !== 1'b1);
      r = datO;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      qM.push_back(m);
      qE.push_back(e);
      bus(0, a, 0);
   endtask
   // Watcher: each read answer is matched to the oldest expectation.
   always @(posedge clk) if (wbAck === 1'b1 && wbWe === 1'b0 && qE.size() > 0)
      cmp("read data", datO & qM.pop_front(), qE.pop_front());
   always @(posedge clk) begin
      cycles++;
      if (cycles > 60000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      void'($urandom(32'hb1d3));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rd(REG_GAINS, 32'hFFFF_FFFF, {KI_RST, KP_RST});
      rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(REG_DUTY, 32'h0000_1FFF, HALF_DUTY);
      spd = 16'(500 + $urandom % 3501);
      bus(1, REG_SPEED_REQ, {16'h0000, spd});
      rd(REG_SPEED_REQ, 32'h0000_FFFF, spd);
      // Low gates come on only after the dead interval has run out.
      repeat (140) @(posedge clk);
      cmp("precharge gates", {gH, gL}, 6'b000_111);
      repeat (700) @(posedge clk);
      rd(REG_STATUS, 32'h0000_00C7, 32'h0000_0083);
      for (int d = 0; d < 4; d++) begin
         // Measured speed now far exceeds the request, so the loop has pulled duty to zero.
         if (d == 2) rd(REG_DUTY, 32'h0000_1FFF, 32'h0000_0000);
         bus(1, REG_CTRL, {28'h000_0000, modes[d]});
         for (int i = 0; i < 6; i++) begin
            hall <= hSeq[i];
            {hi, lo} = modes[d][CTRL_DIR] ? {pSeq[i][2:0], pSeq[i][5:3]} : pSeq[i];
            f = ~(hi | lo);
            repeat (120) @(posedge clk);
            if (d < 2) cmp("gates", {gH, gL} & {lo | f, 3'b111}, {3'b000, lo});
            else if (d == 2) cmp("compl gates", {gH, gL}, {3'b000, hi | lo});
            else cmp("bipolar gates", {gH, gL}, {lo, hi});
            rd(REG_STATUS, 32'h0000_0007, hall);
         end
      end
      estop <= 1;
      repeat (6) @(posedge clk);
      cmp("estop gates", {gH, gL}, 6'b000_000);
      rd(REG_STATUS, 32'h0000_00C8, 32'h0000_00C8);
      estop <= 0;
      ocs <= 1;
      repeat (4) @(posedge clk);
      ocs <= 0;
      repeat (4) @(posedge clk);
      cmp("oc flag", ocFlag, 1'b1);
      cmp("oc gates", {gH, gL}, 6'b000_000);
      bus(1, REG_CTRL, 32'h0000_0008);
      repeat (2) @(posedge clk);
      cmp("oc flag clear", ocFlag, 1'b0);
      sw = 16'($urandom);
      bus(1, REG_SPI, sw);
      do rd(REG_SPI, 32'h0, 32'h0); while (r[SPI_BUSY] !== 1'b0);
      cmp("spi sent", rx, sw);
      rd(REG_SPI, 32'h0000_FFFF, reply);
      conclude();
   end
endmodule // testbench
